// ---- hdl/sls_cfg.svh ----
// Register offsets, field positions and reset values for the lane status block
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH
`define SLS_LANE3_OFFSET 12'h04B3
`define SLS_LANE4_OFFSET 12'h04B4
`define SLS_STATUS_RESET 8'h00
`define SLS_THRESH_RESET 8'h00
`define SLS_BIT_DISPARITY 7
`define SLS_BIT_INVALID 6
`define SLS_BIT_CTRL_CHAR 5
`define SLS_BIT_DESKEW 4
`define SLS_BIT_INIT_SYNC 3
`define SLS_BIT_CHECKSUM 2
`define SLS_BIT_FRAME 1
`define SLS_BIT_CHAR_LOCK 0
`endif

// ---- hdl/sls_lane_status.sv ----
// One lane's registered status byte
`timescale 1ns/100ps
`include "sls_cfg.svh"
module sls_lane_status
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Lane state and threshold
   input wire sls_pkg::sls_lane_in_type lane,
   input wire logic [7:0] error_count_threshold,
   // Status byte
   output logic [7:0] status
);
   wire logic disparity_error_flag;
   wire logic invalid_code_flag;
   wire logic unexpected_control_char_flag;
   wire logic [7:0] next_status;

   assign disparity_error_flag = lane.disparity_err_count >= error_count_threshold;
   assign invalid_code_flag = lane.invalid_code_count >= error_count_threshold;
   assign unexpected_control_char_flag = lane.ctrl_char_count >= error_count_threshold;

   assign next_status = {disparity_error_flag,
                         invalid_code_flag,
                         unexpected_control_char_flag,
                         lane.lane_deskew_done,
                         lane.initial_sync_done,
                         lane.checksum_good,
                         lane.frame_aligned,
                         lane.char_boundary_locked};

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         status <= `SLS_STATUS_RESET;
      else
         status <= next_status;
   end
endmodule

// ---- hdl/sls_link_health.sv ----
// Lane 3 and lane 4 link status registers with shared error threshold
//
// Function
// - Lane 4 status is a read-only byte whose bit 7 is set when its bad disparity count reaches the threshold.
// - Bit 6 is set when the lane's not-in-table count reaches the threshold, else clear.
// - Bit 5 is set when the lane's unexpected control character count reaches the threshold, else clear.
// - Bit 4 shows interlane deskew achieved (1) or failed (0).
// - Bit 3 shows initial lane synchronization achieved (1) or lost (0).
// - Bit 2 shows the received alignment checksum correct (1) or incorrect (0).
// - Bit 1 shows frame synchronization achieved (1) or lost (0).
// - Bit 0 shows code group synchronization achieved (1) or lost (0).
// - Lane 3 has the same status byte at its own offset, resetting to zero.
`timescale 1ns/100ps
`include "sls_cfg.svh"
module sls_link_health
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Lane inputs from the receiver
   input wire sls_pkg::sls_lane_in_type lane3,
   input wire sls_pkg::sls_lane_in_type lane4,
   // Shared threshold and alignment bypass
   input wire logic [7:0] error_count_threshold,
   input wire logic skip_alignment_sequence,
   // Register read port
   input wire sls_pkg::sls_rd_req_type rd_req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // Registered flags
   output logic [7:0] lane_three_link_health,
   output logic [7:0] lane_four_link_health,
   output logic alignment_flags_valid
);
   // ********************************************
   // Per-lane status
   // ********************************************
   // Lane 3 is entry 0 and lane 4 entry 1, the same order as their register offsets
   sls_pkg::sls_lane_in_type lanes [2];
   wire logic [7:0] lane_status [2];

   assign lanes[0] = lane3;
   assign lanes[1] = lane4;

   // One register stage per lane: a flag reaches the status byte one clock after the lane reports it, and a read answer one clock later
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gen_lane
         sls_lane_status sls_lane_status_inst
         (
            .clk_sys(clk_sys),
            .reset(reset),
            .lane(lanes[g]),
            .error_count_threshold(error_count_threshold),
            .status(lane_status[g])
         );
      end
   endgenerate

   assign lane_three_link_health = lane_status[0];
   assign lane_four_link_health = lane_status[1];

   // ********************************************
   // Read port
   // ********************************************
   // Writes are not decoded at all, so both bytes are read-only by construction
   wire logic hit3;
   wire logic hit4;
   wire logic [7:0] next_rd_data;

   assign hit3 = rd_req.rd_addr == `SLS_LANE3_OFFSET;
   assign hit4 = rd_req.rd_addr == `SLS_LANE4_OFFSET;
   // Idle cycles and unmapped offsets answer zero, so a stray read never aliases a lane
   assign next_rd_data = !rd_req.rd_en ? 8'h00 :
                         hit3 ? lane_status[0] :
                         hit4 ? lane_status[1] : 8'h00;

   // rd_valid marks every answer, including the zero of an unmapped read
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         alignment_flags_valid <= 1'b0;
      end
      else
      begin
         rd_data <= next_rd_data;
         rd_valid <= rd_req.rd_en;
         // Hint to software: bits 4..1 carry no meaning while bypassed
         alignment_flags_valid <= !skip_alignment_sequence;
      end
   end

   // ********************************************
   // Checks on lanes 4 and 3 by name and on the read port
   // ********************************************
   // Lane 4 is checked by name here, lane 3 for checksum and char lock; the loop below repeats the checks on both lanes
   a_disparity_flag: assert property (@(posedge clk_sys) disable iff (reset)
      lane4.disparity_err_count >= error_count_threshold |=> lane_status[1][7])
      else $error("Lane 4 disparity flag not set");
   a_invalid_flag: assert property (@(posedge clk_sys) disable iff (reset)
      lane4.invalid_code_count < error_count_threshold |=> !lane_status[1][6])
      else $error("Lane 4 invalid code flag set below threshold");
   a_ctrl_char_flag: assert property (@(posedge clk_sys) disable iff (reset)
      1'b1 |=> lane_status[1][5] == ($past(lane4.ctrl_char_count) >= $past(error_count_threshold)))
      else $error("Lane 4 control char flag wrong");
   a_deskew_bit: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(lane4.lane_deskew_done) |=> lane_status[1][4])
      else $error("Deskew bit did not follow");
   a_init_sync_bit: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(lane4.initial_sync_done) |=> !lane_status[1][3])
      else $error("Initial sync loss not reported");
   a_checksum_bit: assert property (@(posedge clk_sys) disable iff (reset)
      lane3.checksum_good |=> lane_status[0][2])
      else $error("Lane 3 checksum bit wrong");
   a_frame_bit: assert property (@(posedge clk_sys) disable iff (reset)
      !lane4.frame_aligned |=> !lane_status[1][1])
      else $error("Frame loss not reported");
   a_char_lock_bit: assert property (@(posedge clk_sys) disable iff (reset)
      lane3.char_boundary_locked |=> lane_status[0][0])
      else $error("Lane 3 char lock bit wrong");
   // No disable here: this one must hold across reset itself
   a_reset_clear: assert property (@(posedge clk_sys)
      reset |=> lane_status[0] == 8'h00 && lane_status[1] == 8'h00 && !rd_valid)
      else $error("Status not cleared by reset");
   a_read_lane3: assert property (@(posedge clk_sys) disable iff (reset)
      rd_req.rd_en && hit3 |=> rd_valid && rd_data == $past(lane_status[0]))
      else $error("Lane 3 read data wrong");

   // ********************************************
   // Checks repeated on both lanes
   // ********************************************
   // Both polarities of every flag are checked on both lanes, so a bit stuck
   // at either level, or a lane wired to the wrong byte, fails at once.
   // The lane 4 checks above stay as the named reference for that byte.
   generate
      for (g = 0; g < 2; g++)
      begin : gen_lane_check
         // Error flags against the shared threshold
         a_disparity_set: assert property (@(posedge clk_sys) disable iff (reset)
            lanes[g].disparity_err_count >= error_count_threshold |=> lane_status[g][`SLS_BIT_DISPARITY])
            else $error("Disparity flag not set at threshold");
         a_disparity_clear: assert property (@(posedge clk_sys) disable iff (reset)
            lanes[g].disparity_err_count < error_count_threshold |=> !lane_status[g][`SLS_BIT_DISPARITY])
            else $error("Disparity flag set below threshold");
         a_invalid_set: assert property (@(posedge clk_sys) disable iff (reset)
            lanes[g].invalid_code_count >= error_count_threshold |=> lane_status[g][`SLS_BIT_INVALID])
            else $error("Invalid code flag not set at threshold");
         a_invalid_clear: assert property (@(posedge clk_sys) disable iff (reset)
            lanes[g].invalid_code_count < error_count_threshold |=> !lane_status[g][`SLS_BIT_INVALID])
            else $error("Invalid code flag set below threshold");
         a_ctrl_char_set: assert property (@(posedge clk_sys) disable iff (reset)
            lanes[g].ctrl_char_count >= error_count_threshold |=> lane_status[g][`SLS_BIT_CTRL_CHAR])
            else $error("Control char flag not set at threshold");
         a_ctrl_char_clear: assert property (@(posedge clk_sys) disable iff (reset)
            lanes[g].ctrl_char_count < error_count_threshold |=> !lane_status[g][`SLS_BIT_CTRL_CHAR])
            else $error("Control char flag set below threshold");

         // Sync flags follow the lane one clock later
         a_deskew_follow: assert property (@(posedge clk_sys) disable iff (reset)
            1'b1 |=> lane_status[g][`SLS_BIT_DESKEW] == $past(lanes[g].lane_deskew_done))
            else $error("Deskew bit does not follow the lane");
         a_init_sync_follow: assert property (@(posedge clk_sys) disable iff (reset)
            1'b1 |=> lane_status[g][`SLS_BIT_INIT_SYNC] == $past(lanes[g].initial_sync_done))
            else $error("Initial sync bit does not follow the lane");
         a_checksum_follow: assert property (@(posedge clk_sys) disable iff (reset)
            1'b1 |=> lane_status[g][`SLS_BIT_CHECKSUM] == $past(lanes[g].checksum_good))
            else $error("Checksum bit does not follow the lane");
         a_frame_follow: assert property (@(posedge clk_sys) disable iff (reset)
            1'b1 |=> lane_status[g][`SLS_BIT_FRAME] == $past(lanes[g].frame_aligned))
            else $error("Frame bit does not follow the lane");
         a_char_lock_follow: assert property (@(posedge clk_sys) disable iff (reset)
            1'b1 |=> lane_status[g][`SLS_BIT_CHAR_LOCK] == $past(lanes[g].char_boundary_locked))
            else $error("Char lock bit does not follow the lane");
      end
   endgenerate

   // ********************************************
   // Checks on the read port, the hint, the zero threshold and equal lanes
   // ********************************************
   // A read answer is the byte as registered on the request edge
   a_read_lane4: assert property (@(posedge clk_sys) disable iff (reset)
      rd_req.rd_en && hit4 |=> rd_valid && rd_data == $past(lane_status[1]))
      else $error("Lane 4 read data wrong");
   a_read_unmapped: assert property (@(posedge clk_sys) disable iff (reset)
      rd_req.rd_en && !hit3 && !hit4 |=> rd_valid && rd_data == 8'h00)
      else $error("Unmapped read returned data");
   a_read_idle: assert property (@(posedge clk_sys) disable iff (reset)
      !rd_req.rd_en |=> !rd_valid && rd_data == 8'h00)
      else $error("Read answer without a request");
   a_rd_valid_follow: assert property (@(posedge clk_sys) disable iff (reset)
      rd_req.rd_en |=> rd_valid)
      else $error("Read request not answered");
   a_bypass_hint: assert property (@(posedge clk_sys) disable iff (reset)
      1'b1 |=> alignment_flags_valid == !$past(skip_alignment_sequence))
      else $error("Alignment flag hint wrong");
   a_zero_threshold: assert property (@(posedge clk_sys) disable iff (reset)
      error_count_threshold == 8'h00 |=> lane_status[0][7:5] == 3'h7 && lane_status[1][7:5] == 3'h7)
      else $error("Zero threshold did not raise all error flags");
   a_lane_match: assert property (@(posedge clk_sys) disable iff (reset)
      lane3 == lane4 |=> lane_status[0] == lane_status[1])
      else $error("Equal lanes gave different bytes");

   // ********************************************
   // Coverage
   // ********************************************
   // Main scenarios: a read with a flag up, full sync, bypass, zero threshold, resume after reset
   c_read_lane4: cover property (@(posedge clk_sys) disable iff (reset)
      rd_req.rd_en && hit4 ##1 rd_data[7]);
   c_full_sync: cover property (@(posedge clk_sys) disable iff (reset)
      lane_status[1][4:0] == 5'h1F);
   c_bypass: cover property (@(posedge clk_sys) disable iff (reset)
      $fell(alignment_flags_valid));
   c_zero_threshold: cover property (@(posedge clk_sys) disable iff (reset)
      error_count_threshold == 8'h00 ##1 lane_status[1][7:5] == 3'h7);
   c_reset_resume: cover property (@(posedge clk_sys)
      $fell(reset) ##1 lane_status[1] != 8'h00);
endmodule

// ---- hdl/sls_pkg.sv ----
// Types shared by the lane status block
package sls_pkg;
   // Per-lane inputs from the receive lane logic
   typedef struct packed {
      logic [7:0] disparity_err_count;
      logic [7:0] invalid_code_count;
      logic [7:0] ctrl_char_count;
      logic lane_deskew_done;
      logic initial_sync_done;
      logic checksum_good;
      logic frame_aligned;
      logic char_boundary_locked;
   } sls_lane_in_type;

   // Register read port
   typedef struct packed {
      logic rd_en;
      logic [11:0] rd_addr;
   } sls_rd_req_type;
endpackage

// ---- verification/sls_lane_model.sv ----
// Behavioural receive lane logic of one lane: error counts and sync states
`timescale 1ns/100ps
module sls_lane_model
(
   // Clock
   input wire logic clk_sys,
   // Requested lane state
   input wire logic [23:0] counts,
   input wire logic [4:0] states,
   // Lane state toward the status block
   output sls_pkg::sls_lane_in_type lane
);
   // Changes land just after the edge, as from real lane logic
   always @(posedge clk_sys)
   begin
      lane <= #1 {counts, states};
   end
endmodule

// ---- verification/sls_link_health_bench.sv ----
// Self-checking bench for the lane 3 and lane 4 status registers
`timescale 1ns/100ps
module sls_link_health_bench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [23:0] c3 = '0, c4 = '0;
   logic [4:0] s3 = '0, s4 = '0;
   // A threshold of one keeps the idle lanes' error flags clear after reset
   logic [7:0] thr = 8'h01;
   logic skip = 1'b0;
   sls_pkg::sls_rd_req_type rd_req = '0;
   sls_pkg::sls_lane_in_type lane3, lane4;
   logic [7:0] rd_data, h3, h4;
   logic rd_valid, fv;
   int miscompares = 0;
   int samples_checked = 0;
   always #4 clk_sys = ~clk_sys;
   sls_lane_model m3_inst (.clk_sys(clk_sys), .counts(c3), .states(s3), .lane(lane3));
   sls_lane_model m4_inst (.clk_sys(clk_sys), .counts(c4), .states(s4), .lane(lane4));
   sls_link_health sls_link_health_inst (.clk_sys(clk_sys), .reset(reset), .lane3(lane3), .lane4(lane4),
      .error_count_threshold(thr), .skip_alignment_sequence(skip), .rd_req(rd_req), .rd_data(rd_data),
      .rd_valid(rd_valid), .lane_three_link_health(h3), .lane_four_link_health(h4), .alignment_flags_valid(fv));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bytes are one register stage behind the lane, so read only after both stages settle
   task rd(input logic [11:0] addr, input logic [7:0] exp);
      @(posedge clk_sys) #1 rd_req = {1'b1, addr};
      @(posedge clk_sys) #1 rd_req = '0;
      chk({7'h00, rd_valid}, 8'h01);
      chk(rd_data, exp);
   endtask
   function automatic logic [7:0] want(input logic [23:0] c, input logic [4:0] s, input logic [7:0] t);
      return {c[23:16] >= t, c[15:8] >= t, c[7:0] >= t, s};
   endfunction
   task drive(input logic [23:0] a3, input logic [4:0] b3, input logic [23:0] a4, input logic [4:0] b4);
      c3 = a3;
      s3 = b3;
      c4 = a4;
      s4 = b4;
      repeat (3) @(posedge clk_sys);
      #1 chk(h4, want(a4, b4, thr));
      chk(h3, want(a3, b3, thr));
      rd(12'h04B4, want(a4, b4, thr));
      rd(12'h04B3, want(a3, b3, thr));
   endtask
   task scen_reset;
      rd(12'h04B3, 8'h00);
      rd(12'h04B4, 8'h00);
      rd(12'h04B5, 8'h00);
      // No request on this edge, so the answer must drop back to idle
      @(posedge clk_sys) #1 chk({7'h00, rd_valid}, 8'h00);
      chk(rd_data, 8'h00);
   endtask
   task scen_threshold;
      thr = 8'h05;
      drive(24'h0504_06, 5'h00, 24'h0405_05, 5'h00);
      drive(24'h0405_05, 5'h00, 24'h0504_04, 5'h00);
      thr = 8'h00;
      drive(24'h0000_00, 5'h00, 24'h0000_00, 5'h00);
      thr = 8'hFF;
      drive(24'hFFFE_FF, 5'h00, 24'hFEFF_FE, 5'h00);
   endtask
   task scen_flags;
      thr = 8'h10;
      for (int i = 0; i < 5; i++)
      begin
         drive(24'h0000_00, 5'(1 << i), 24'h0F0F_0F, ~5'(1 << i));
      end
   endtask
   task scen_bypass;
      skip = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk({7'h00, fv}, 8'h00);
      skip = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk({7'h00, fv}, 8'h01);
   endtask
   task scen_mid_reset;
      drive(24'h0000_00, 5'h1F, 24'h0000_00, 5'h1F);
      reset = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk(h4, 8'h00);
      chk(h3, 8'h00);
      reset = 1'b0;
      // First edge after release: the bytes follow the unchanged lanes again
      @(posedge clk_sys) #1 chk(h4, 8'h1F);
      chk(h3, 8'h1F);
   endtask
   task final_report;
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      #1 chk(h3, 8'h00);
      chk(h4, 8'h00);
      chk({6'h00, rd_valid, fv}, 8'h00);
      reset = 1'b0;
      scen_reset();
      scen_threshold();
      scen_flags();
      scen_bypass();
      scen_mid_reset();
      final_report();
   end
endmodule
